// >>> logic/gpio_pkg.sv
package gpio_pkg;

  // ---------------------------------------------------------------
  // Register word offsets
  // ---------------------------------------------------------------
  localparam logic [5:0] OFF_A_DATA = 6'h00;
  localparam logic [5:0] OFF_A_DIR = 6'h01;
  localparam logic [5:0] OFF_A_PULL = 6'h02;
  localparam logic [5:0] OFF_A_WAKE = 6'h03;
  localparam logic [5:0] OFF_B_DATA = 6'h04;
  localparam logic [5:0] OFF_B_DIR = 6'h05;
  localparam logic [5:0] OFF_B_PULL = 6'h06;
  localparam logic [5:0] OFF_C_DATA = 6'h07;
  localparam logic [5:0] OFF_C_DIR = 6'h08;
  localparam logic [5:0] OFF_C_PULL = 6'h09;
  localparam logic [5:0] OFF_D_DATA = 6'h0A;
  localparam logic [5:0] OFF_D_DIR = 6'h0B;
  localparam logic [5:0] OFF_D_PULL = 6'h0C;
  localparam logic [5:0] OFF_CTRL = 6'h0D;
  localparam logic [5:0] OFF_IRQ_STAT = 6'h0E;
  localparam logic [5:0] OFF_IRQ_MASK = 6'h0F;

  // ---------------------------------------------------------------
  // Implemented bit masks
  // ---------------------------------------------------------------
  localparam logic [7:0] MASK_A_PULL = 8'h7F;
  localparam logic [7:0] MASK_B = 8'h3F;
  localparam logic [7:0] MASK_C = 8'hFF;
  localparam logic [7:0] MASK_D = 8'h0F;
  localparam logic [7:0] MASK_IRQ = 8'h01;

  // ---------------------------------------------------------------
  // Reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_A_DIR = 8'hFF;
  localparam logic [7:0] RST_B_DIR = 8'h3F;
  localparam logic [7:0] RST_C_DIR = 8'hFF;
  localparam logic [7:0] RST_D_DIR = 8'h0F;
  localparam logic [7:0] RST_PULL = 8'h00;
  localparam logic [7:0] RST_WAKE = 8'h00;
  localparam logic [7:0] RST_DATA = 8'hFF;

  // ---------------------------------------------------------------
  // Control bits and bus answer
  // ---------------------------------------------------------------
  localparam int CTRL_HALT_BIT = 0;
  localparam int IRQ_WAKE_BIT = 0;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

  typedef enum logic [1:0] {
    AVL_IDLE,
    AVL_ANSWER
  } avl_state_e;

  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
    logic [7:0] pull;
  } pin_drive_s;

endpackage

// >>> logic/gpio_pin_sync.sv
`timescale 1ns/100ps
`default_nettype none

module gpio_pin_sync (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [7:0] pin_i,
  output logic [7:0] level_o
);

  logic [7:0] meta_q;

  // ---------------------------------------------------------------
  // Two-stage synchroniser, reset to pulled-high idle level
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      meta_q <= 8'hFF;
      level_o <= 8'hFF;
    end else begin
      meta_q <= pin_i;
      level_o <= meta_q;
    end
  end

endmodule

`default_nettype wire

// >>> logic/gpio_wake_detect.sv
`timescale 1ns/100ps
`default_nettype none

module gpio_wake_detect (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [7:0] level_i,
  input wire logic [7:0] enable_i,
  output logic wake_o
);

  logic [7:0] prev_q;

  // ---------------------------------------------------------------
  // Falling edge per enabled pin against last sampled level
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      prev_q <= 8'hFF;
    end else begin
      prev_q <= level_i; // RL16
    end
  end

  assign wake_o = |(prev_q & ~level_i & enable_i); // RL6 RL7

endmodule

`default_nettype wire

// >>> logic/io_ports_pullup_wake.sv
`timescale 1ns/100ps
`default_nettype none

// Summary of operation
// RL1: Port reads return pin level at read time; no input latch.
// RL2: Output latch holds written data until software rewrites it.
// RL3: Input pins may enable a weak pull-high per pin.
// RL4: Port A top pin has no pull-high; bit 7 unimplemented.
// RL5: Halt enters idle/sleep, stopping the system clock.
// RL6: In sleep, enabled port A falling edge wakes device.
// RL7: Each port A wake-enable bit enables its own pin.
// RL8: Direction 1 makes an input, 0 a push-pull output.
// RL9: Reading an output pin returns the actual pin level.
// RL10: Pull-high bit 1 connects, 0 disconnects; resets to zero.
// RL11: Port A wake-enable resets to all zeros.
// RL12: Port A and C direction reset to all ones.
// RL13: Port B has six direction bits, resetting to ones.
// RL14: Port D has four direction bits and four pull-high bits.
// RL15: Unimplemented configuration bits read zero, ignore writes.
// RL16: Wake detect compares enabled pins to previous sample.
module io_ports_pullup_wake (
  input wire logic clock_i,
  input wire logic rst_i,
  input wire logic [5:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  output logic irq_o,
  output logic sleep_o,
  output logic wake_o,
  input wire logic [7:0] port_a_pins_i,
  output gpio_pkg::pin_drive_s port_a_o,
  input wire logic [7:0] port_b_pins_i,
  output gpio_pkg::pin_drive_s port_b_o,
  input wire logic [7:0] port_c_pins_i,
  output gpio_pkg::pin_drive_s port_c_o,
  input wire logic [7:0] port_d_pins_i,
  output gpio_pkg::pin_drive_s port_d_o
);

  gpio_pkg::avl_state_e state_q;
  logic [7:0] a_data_q, b_data_q, c_data_q, d_data_q;
  logic [7:0] a_dir_q, b_dir_q, c_dir_q, d_dir_q;
  logic [7:0] a_pull_q, b_pull_q, c_pull_q, d_pull_q;
  logic [7:0] wake_en_q;
  logic [7:0] irq_stat_q, irq_mask_q;
  logic sleep_q;
  logic [7:0] a_lvl, b_lvl, c_lvl, d_lvl;
  logic wake_edge;
  logic take, wr_go, rd_go;
  logic [7:0] wbyte, rd_byte;

  // ---------------------------------------------------------------
  // Pin synchronisers
  // ---------------------------------------------------------------
  gpio_pin_sync sync_a (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .pin_i(port_a_pins_i),
    .level_o(a_lvl)
  );
  gpio_pin_sync sync_b (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .pin_i(port_b_pins_i),
    .level_o(b_lvl)
  );
  gpio_pin_sync sync_c (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .pin_i(port_c_pins_i),
    .level_o(c_lvl)
  );
  gpio_pin_sync sync_d (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .pin_i(port_d_pins_i),
    .level_o(d_lvl)
  );

  // ---------------------------------------------------------------
  // Wake detection on port A
  // ---------------------------------------------------------------
  gpio_wake_detect wake_det (
    .clock_i(clock_i),
    .rst_i(rst_i),
    .level_i(a_lvl),
    .enable_i(wake_en_q),
    .wake_o(wake_edge)
  );

  function automatic logic [7:0] wr_field(input logic [7:0] old,
                                          input logic [7:0] val,
                                          input logic [7:0] mask);
    wr_field = (old & ~mask) | (val & mask);
  endfunction

  // ---------------------------------------------------------------
  // Avalon slave: one wait cycle, answer in second cycle
  // ---------------------------------------------------------------
  assign take = (state_q == gpio_pkg::AVL_ANSWER);
  assign waitrequest = (read | write) & ~take;
  assign wr_go = write & take & byteenable[0];
  assign rd_go = read & take;
  assign wbyte = writedata[7:0];

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      state_q <= gpio_pkg::AVL_IDLE;
    end else begin
      case (state_q)
        gpio_pkg::AVL_IDLE: begin
          if (read | write) begin
            state_q <= gpio_pkg::AVL_ANSWER;
          end
        end
        default: begin
          state_q <= gpio_pkg::AVL_IDLE;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Output latches
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      a_data_q <= gpio_pkg::RST_DATA;
      b_data_q <= gpio_pkg::RST_DATA & gpio_pkg::MASK_B;
      c_data_q <= gpio_pkg::RST_DATA;
      d_data_q <= gpio_pkg::RST_DATA & gpio_pkg::MASK_D;
    end else if (wr_go) begin
      if (address == gpio_pkg::OFF_A_DATA) begin
        a_data_q <= wbyte; // RL2
      end else if (address == gpio_pkg::OFF_B_DATA) begin
        b_data_q <= wbyte & gpio_pkg::MASK_B; // RL2
      end else if (address == gpio_pkg::OFF_C_DATA) begin
        c_data_q <= wbyte & gpio_pkg::MASK_C; // RL2
      end else if (address == gpio_pkg::OFF_D_DATA) begin
        d_data_q <= wbyte & gpio_pkg::MASK_D; // RL2
      end
    end
  end

  // ---------------------------------------------------------------
  // Direction registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      a_dir_q <= gpio_pkg::RST_A_DIR; // RL12
      b_dir_q <= gpio_pkg::RST_B_DIR; // RL13
      c_dir_q <= gpio_pkg::RST_C_DIR; // RL12
      d_dir_q <= gpio_pkg::RST_D_DIR; // RL14
    end else if (wr_go) begin
      if (address == gpio_pkg::OFF_A_DIR) begin
        a_dir_q <= wbyte;
      end else if (address == gpio_pkg::OFF_B_DIR) begin
        b_dir_q <= wbyte & gpio_pkg::MASK_B; // RL13 RL15
      end else if (address == gpio_pkg::OFF_C_DIR) begin
        c_dir_q <= wbyte & gpio_pkg::MASK_C;
      end else if (address == gpio_pkg::OFF_D_DIR) begin
        d_dir_q <= wbyte & gpio_pkg::MASK_D; // RL14 RL15
      end
    end
  end

  // ---------------------------------------------------------------
  // Pull-high and wake-enable registers
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      a_pull_q <= gpio_pkg::RST_PULL; // RL10
      b_pull_q <= gpio_pkg::RST_PULL; // RL10
      c_pull_q <= gpio_pkg::RST_PULL; // RL10
      d_pull_q <= gpio_pkg::RST_PULL; // RL10
      wake_en_q <= gpio_pkg::RST_WAKE; // RL11
    end else if (wr_go) begin
      if (address == gpio_pkg::OFF_A_PULL) begin
        a_pull_q <= wbyte & gpio_pkg::MASK_A_PULL; // RL4 RL15
      end else if (address == gpio_pkg::OFF_B_PULL) begin
        b_pull_q <= wbyte & gpio_pkg::MASK_B; // RL15
      end else if (address == gpio_pkg::OFF_C_PULL) begin
        c_pull_q <= wbyte & gpio_pkg::MASK_C;
      end else if (address == gpio_pkg::OFF_D_PULL) begin
        d_pull_q <= wbyte & gpio_pkg::MASK_D; // RL14 RL15
      end else if (address == gpio_pkg::OFF_A_WAKE) begin
        wake_en_q <= wbyte; // RL7
      end
    end
  end

  // ---------------------------------------------------------------
  // Halt, sleep and wake
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      sleep_q <= 1'b0;
    end else if (sleep_q && wake_edge) begin
      sleep_q <= 1'b0; // RL6
    end else if (wr_go && address == gpio_pkg::OFF_CTRL &&
                 wbyte[gpio_pkg::CTRL_HALT_BIT]) begin
      sleep_q <= 1'b1; // RL5
    end
  end

  assign sleep_o = sleep_q;
  assign wake_o = sleep_q & wake_edge;

  // ---------------------------------------------------------------
  // Interrupt status and mask
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      irq_stat_q <= 8'h00;
      irq_mask_q <= 8'h00;
    end else begin
      // Clear only the bits just returned; a newer event survives
      if (rd_go && address == gpio_pkg::OFF_IRQ_STAT) begin
        irq_stat_q <= irq_stat_q & ~readdata[7:0];
      end
      if (sleep_q && wake_edge) begin
        irq_stat_q[gpio_pkg::IRQ_WAKE_BIT] <= 1'b1;
      end
      if (wr_go && address == gpio_pkg::OFF_IRQ_MASK) begin
        irq_mask_q <= wbyte & gpio_pkg::MASK_IRQ;
      end
    end
  end

  assign irq_o = |(irq_stat_q & irq_mask_q);

  // ---------------------------------------------------------------
  // Read mux and read data register
  // ---------------------------------------------------------------
  always_comb begin
    rd_byte = 8'h00;
    if (address == gpio_pkg::OFF_A_DATA) begin
      rd_byte = a_lvl; // RL1 RL9
    end else if (address == gpio_pkg::OFF_A_DIR) begin
      rd_byte = a_dir_q;
    end else if (address == gpio_pkg::OFF_A_PULL) begin
      rd_byte = a_pull_q;
    end else if (address == gpio_pkg::OFF_A_WAKE) begin
      rd_byte = wake_en_q;
    end else if (address == gpio_pkg::OFF_B_DATA) begin
      rd_byte = b_lvl & gpio_pkg::MASK_B; // RL1 RL9 RL15
    end else if (address == gpio_pkg::OFF_B_DIR) begin
      rd_byte = b_dir_q;
    end else if (address == gpio_pkg::OFF_B_PULL) begin
      rd_byte = b_pull_q;
    end else if (address == gpio_pkg::OFF_C_DATA) begin
      rd_byte = c_lvl & gpio_pkg::MASK_C; // RL1 RL9
    end else if (address == gpio_pkg::OFF_C_DIR) begin
      rd_byte = c_dir_q;
    end else if (address == gpio_pkg::OFF_C_PULL) begin
      rd_byte = c_pull_q;
    end else if (address == gpio_pkg::OFF_D_DATA) begin
      rd_byte = d_lvl & gpio_pkg::MASK_D; // RL1 RL9 RL15
    end else if (address == gpio_pkg::OFF_D_DIR) begin
      rd_byte = d_dir_q;
    end else if (address == gpio_pkg::OFF_D_PULL) begin
      rd_byte = d_pull_q;
    end else if (address == gpio_pkg::OFF_CTRL) begin
      rd_byte = {7'h00, sleep_q};
    end else if (address == gpio_pkg::OFF_IRQ_STAT) begin
      rd_byte = irq_stat_q;
    end else if (address == gpio_pkg::OFF_IRQ_MASK) begin
      rd_byte = irq_mask_q;
    end
  end

  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      readdata <= gpio_pkg::UNMAPPED_READ;
    end else if (read & ~take) begin
      readdata <= {24'h000000, rd_byte};
    end
  end

  // ---------------------------------------------------------------
  // Pin drive: output enable on direction 0, pull on inputs only
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (rst_i) begin
      port_a_o <= '0;
      port_b_o <= '0;
      port_c_o <= '0;
      port_d_o <= '0;
    end else begin
      port_a_o <= '{out: a_data_q, oe: ~a_dir_q, // RL8
                    pull: a_pull_q & a_dir_q}; // RL3 RL10
      port_b_o <= '{out: b_data_q, oe: ~b_dir_q & gpio_pkg::MASK_B,
                    pull: b_pull_q & b_dir_q}; // RL3 RL8
      port_c_o <= '{out: c_data_q, oe: ~c_dir_q & gpio_pkg::MASK_C,
                    pull: c_pull_q & c_dir_q}; // RL3 RL8
      port_d_o <= '{out: d_data_q, oe: ~d_dir_q & gpio_pkg::MASK_D,
                    pull: d_pull_q & d_dir_q}; // RL3 RL8
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_pull_top_a: assert property (@(posedge clock_i) disable iff (rst_i) // RL4
    !a_pull_q[7] && !port_a_o.pull[7])
    else $error("port A bit 7 pull-high set");

  wake_clear_a: assert property (@(posedge clock_i) disable iff (rst_i) // RL6
    (sleep_q && wake_edge) |=> !sleep_q && irq_stat_q[0])
    else $error("wake did not leave sleep");

  halt_sleep_a: assert property (@(posedge clock_i) disable iff (rst_i) // RL5
    (wr_go && address == gpio_pkg::OFF_CTRL && wbyte[0] && !sleep_q)
    |=> sleep_q)
    else $error("halt did not enter sleep");

  dir_oe_a: assert property (@(posedge clock_i) disable iff (rst_i) // RL8
    ##1 (port_a_o.oe == ~$past(a_dir_q)))
    else $error("port A enable mismatch");

  b_dir_top_a: assert property (@(posedge clock_i) disable iff (rst_i) // RL13
    b_dir_q[7:6] == 2'b00)
    else $error("port B upper direction bits set");

  d_dir_top_a: assert property (@(posedge clock_i) disable iff (rst_i) // RL14
    d_dir_q[7:4] == 4'h0 && d_pull_q[7:4] == 4'h0)
    else $error("port D upper bits set");

  latch_hold_a: assert property (@(posedge clock_i) disable iff (rst_i) // RL2
    !(wr_go && address == gpio_pkg::OFF_A_DATA) |=> $stable(a_data_q))
    else $error("port A latch changed without write");

  pull_input_a: assert property (@(posedge clock_i) disable iff (rst_i) // RL3
    (port_c_o.pull & port_c_o.oe) == 8'h00)
    else $error("pull-high on output pin");

  wake_gate_a: assert property (@(posedge clock_i) disable iff (rst_i) // RL7
    (wake_en_q == 8'h00) |-> !wake_edge)
    else $error("wake with all enables off");

endmodule

`default_nettype wire

// >>> tb/pin_board.sv
`timescale 1ns/100ps
`default_nettype none

module pin_board (
  input wire logic clock_i,
  input wire gpio_pkg::pin_drive_s drv_i,
  input wire logic [7:0] ext_i,
  input wire logic [7:0] ext_en_i,
  output logic [7:0] pins_o
);
  logic [7:0] float_q = 8'hA5;

  // ---------------------------------------------------------------
  // Floating pins wander so no stale level is read back
  // ---------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    float_q <= ~float_q;
  end

  // ---------------------------------------------------------------
  // Pin level: push-pull driver, then switch, then weak pull-high
  // ---------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (drv_i.oe[i]) begin
        pins_o[i] = drv_i.out[i];
      end else if (ext_en_i[i]) begin
        pins_o[i] = ext_i[i];
      end else if (drv_i.pull[i]) begin
        pins_o[i] = 1'b1;
      end else begin
        pins_o[i] = float_q[i];
      end
    end
  end
endmodule

`default_nettype wire

// >>> tb/tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module tb_top;
  logic clock_i = 1'b0;
  logic rst_i = 1'b1;
  logic [5:0] address = 6'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0000_0000;
  logic [3:0] byteenable = 4'hF;
  logic [31:0] readdata;
  logic waitrequest;
  logic irq_o;
  logic sleep_o;
  logic wake_o;
  logic [7:0] pins [4];
  logic [7:0] ext [4] = '{default: 8'hFF};
  logic [7:0] ext_en [4] = '{default: 8'h00};
  gpio_pkg::pin_drive_s drv [4];
  int n_fail = 0;
  int total_checks = 0;
  int n_wake = 0;
  logic [31:0] rd;
  logic [5:0] cfg_off [9] = '{gpio_pkg::OFF_A_DIR, gpio_pkg::OFF_A_PULL,
    gpio_pkg::OFF_A_WAKE, gpio_pkg::OFF_B_DIR, gpio_pkg::OFF_B_PULL,
    gpio_pkg::OFF_C_DIR, gpio_pkg::OFF_C_PULL, gpio_pkg::OFF_D_DIR,
    gpio_pkg::OFF_D_PULL};
  logic [7:0] rst_val [9] = '{8'hFF, 8'h00, 8'h00, 8'h3F, 8'h00, 8'hFF,
    8'h00, 8'h0F, 8'h00};
  logic [7:0] impl [9] = '{8'hFF, 8'h7F, 8'hFF, 8'h3F, 8'h3F, 8'hFF,
    8'hFF, 8'h0F, 8'h0F};

  always #10 clock_i = ~clock_i;

  // Count wake pulses seen at the clock edge
  always @(posedge clock_i) begin
    if (wake_o === 1'b1) begin
      n_wake++;
    end
  end

  io_ports_pullup_wake uut (
    .clock_i(clock_i), .rst_i(rst_i), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable),
    .readdata(readdata), .waitrequest(waitrequest), .irq_o(irq_o),
    .sleep_o(sleep_o), .wake_o(wake_o),
    .port_a_pins_i(pins[0]), .port_a_o(drv[0]),
    .port_b_pins_i(pins[1]), .port_b_o(drv[1]),
    .port_c_pins_i(pins[2]), .port_c_o(drv[2]),
    .port_d_pins_i(pins[3]), .port_d_o(drv[3])
  );

  for (genvar g = 0; g < 4; g++) begin : g_board
    pin_board board (
      .clock_i(clock_i), .drv_i(drv[g]), .ext_i(ext[g]),
      .ext_en_i(ext_en[g]), .pins_o(pins[g])
    );
  end

  // ---------------------------------------------------------------
  // Closing report and shared checks
  // ---------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks=%0d failures=%0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // ---------------------------------------------------------------
  // Avalon-MM cycle, held until waitrequest is sampled low
  // ---------------------------------------------------------------
  task automatic bus(input logic wr, input logic [5:0] a,
                     input logic [7:0] d, input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clock_i);
    address <= a;
    read <= ~wr;
    write <= wr;
    writedata <= {24'h00_0000, d};
    byteenable <= be;
    do begin
      @(posedge clock_i);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (waitrequest !== 1'b0) begin
      n_fail++;
      report_and_stop();
    end
  endtask

  task automatic wr_reg(input logic [5:0] a, input logic [7:0] d);
    bus(1'b1, a, d, 4'h1);
  endtask

  task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp);
    bus(1'b0, a, 8'h00, 4'hF);
    check(rd, {24'h00_0000, exp});
  endtask

  task automatic wait_wake();
    int n;
    n = 0;
    while (sleep_o !== 1'b0 && n < 20) begin
      @(posedge clock_i);
      n++;
    end
    if (sleep_o !== 1'b0) begin
      n_fail++;
      report_and_stop();
    end
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (20) @(posedge clock_i);
    rst_i <= 1'b0;
    repeat (2) @(posedge clock_i);
    check(drv[0].oe, 8'h00);
    check(drv[0].pull, 8'h00);
    for (int i = 0; i < 9; i++) begin
      rd_chk(cfg_off[i], rst_val[i]);
    end
    for (int i = 0; i < 9; i++) begin
      wr_reg(cfg_off[i], 8'hFF);
      rd_chk(cfg_off[i], impl[i]);
      wr_reg(cfg_off[i], 8'h00);
      rd_chk(cfg_off[i], 8'h00);
    end
    wr_reg(gpio_pkg::OFF_A_DATA, 8'h5A);
    repeat (2) @(posedge clock_i);
    check(drv[0].oe, 8'hFF);
    check(drv[0].out, 8'h5A);
    rd_chk(gpio_pkg::OFF_A_DATA, 8'h5A);
    wr_reg(gpio_pkg::OFF_A_DIR, 8'hFF);
    wr_reg(gpio_pkg::OFF_A_PULL, 8'hFF);
    repeat (2) @(posedge clock_i);
    check(drv[0].oe, 8'h00);
    check(drv[0].pull, 8'h7F);
    ext[0] <= 8'h3C;
    ext_en[0] <= 8'hFF;
    repeat (3) @(posedge clock_i);
    rd_chk(gpio_pkg::OFF_A_DATA, 8'h3C);
    ext[0] <= 8'hC3;
    repeat (3) @(posedge clock_i);
    rd_chk(gpio_pkg::OFF_A_DATA, 8'hC3);
    wr_reg(gpio_pkg::OFF_A_DIR, 8'h00);
    check(drv[0].out, 8'h5A);
    wr_reg(gpio_pkg::OFF_C_DIR, 8'hFF);
    wr_reg(gpio_pkg::OFF_C_PULL, 8'hFF);
    repeat (2) @(posedge clock_i);
    check(drv[2].pull, 8'hFF);
    repeat (3) @(posedge clock_i);
    rd_chk(gpio_pkg::OFF_C_DATA, 8'hFF);
    // Refused writes: no byte lane, unmapped index
    bus(1'b1, gpio_pkg::OFF_A_WAKE, 8'h01, 4'h0);
    rd_chk(gpio_pkg::OFF_A_WAKE, 8'h00);
    wr_reg(6'h20, 8'hFF);
    rd_chk(6'h20, 8'h00);
    // Wake from sleep on an enabled falling edge only
    ext[0] <= 8'hFF;
    wr_reg(gpio_pkg::OFF_A_DIR, 8'hFF);
    wr_reg(gpio_pkg::OFF_A_WAKE, 8'h01);
    wr_reg(gpio_pkg::OFF_IRQ_MASK, 8'h01);
    bus(1'b0, gpio_pkg::OFF_IRQ_STAT, 8'h00, 4'hF);
    wr_reg(gpio_pkg::OFF_CTRL, 8'h01);
    @(posedge clock_i);
    check(sleep_o, 1'b1);
    rd_chk(gpio_pkg::OFF_CTRL, 8'h01);
    ext[0] <= 8'hFD;
    repeat (6) @(posedge clock_i);
    check(sleep_o, 1'b1);
    check(irq_o, 1'b0);
    ext[0] <= 8'hFC;
    wait_wake();
    check(n_wake, 32'h0000_0001);
    check(irq_o, 1'b1);
    rd_chk(gpio_pkg::OFF_IRQ_STAT, 8'h01);
    @(posedge clock_i);
    check(irq_o, 1'b0);
    rd_chk(gpio_pkg::OFF_IRQ_STAT, 8'h00);
    // Masked wake still sets status, keeps interrupt low
    ext[0] <= 8'hFF;
    wr_reg(gpio_pkg::OFF_IRQ_MASK, 8'h00);
    wr_reg(gpio_pkg::OFF_CTRL, 8'h01);
    @(posedge clock_i);
    check(sleep_o, 1'b1);
    ext[0] <= 8'hFE;
    wait_wake();
    check(n_wake, 32'h0000_0002);
    check(irq_o, 1'b0);
    rd_chk(gpio_pkg::OFF_IRQ_STAT, 8'h01);
    report_and_stop();
  end
endmodule

`default_nettype wire
